// ---- rtl/bcc_top.sv ----
`timescale 1ns/1ps
// How it works
// RQ1: run, instruction phase, memory enable low gives streaming fetch label.
// RQ2: run instruction phase is run cycle, refined to exception or swapped.
// RQ3: stall instruction phase, memory enable low, read busy gives retried read.
// RQ4: stall with memory enable low: fixup read if exception low, else refill.
// RQ5: otherwise stall instruction phase: fixup if exception low, else stall.
// RQ6: flag uncached fetch on phase, memory enable low, both writes high.
// RQ7: flag main-memory instruction read on phase and memory enable low.
// RQ8: data-cache read with size bit 2 low decodes byte, half, tri, word.
// RQ9: data-cache read with no sized match is a plain data read.
// RQ10: run data phase with icache read low is swapped data read.
// RQ11: main-memory write with size bit 2 low decodes byte to word.
// RQ12: main-memory write with no sized match is a plain data write.
// RQ13: first matching label wins; nothing classified while target reset low.
// RQ14: all strobes but main-memory read high, size bit 2 low in run data phase is coprocessor move.
module bcc_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire bcc_pkg::bcc_ctrl_t ctrl,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output bcc_pkg::bcc_label_t label,
	output logic uncached_fetch,
	output logic main_mem_ifetch,
	output logic label_valid
);

	function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
			input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == bcc_pkg::BCC_OFS_CTRL) || (addr == bcc_pkg::BCC_OFS_STATUS)
			|| (addr == bcc_pkg::BCC_OFS_SAMPLE) || (addr == bcc_pkg::BCC_OFS_SEEN)
			|| (addr == bcc_pkg::BCC_OFS_COUNT);
	endfunction

	// ---- classification of the live control group
	bcc_pkg::bcc_class_t live_class;
	bcc_pkg::bcc_class_t class_q;
	bcc_pkg::bcc_class_t next_class_q;
	bcc_pkg::bcc_ctrl_t sample_q;
	bcc_pkg::bcc_ctrl_t next_sample_q;

	bcc_classify u_classify (
		.ctrl(ctrl),
		.result(live_class)
	);

	// ---- software state
	logic [31:0] ctrl_reg;
	logic [31:0] next_ctrl_reg;
	logic [31:0] seen;
	logic [31:0] next_seen;
	logic frozen;
	logic next_frozen;
	logic [31:0] match_count;
	logic [31:0] next_prdata;
	logic next_pslverr;

	logic capture_en;
	logic freeze_en;
	logic [4:0] match_sel;
	logic setup_phase;
	logic access_wr;
	logic wr_ctrl;
	logic wr_seen;
	logic wr_count;
	logic sample_active;
	logic match_hit;
	logic [31:0] seen_set;
	logic [31:0] status_word;

	assign capture_en = ctrl_reg[bcc_pkg::BCC_CTRL_ENABLE_BIT];
	assign freeze_en = ctrl_reg[bcc_pkg::BCC_CTRL_FREEZE_BIT];
	assign match_sel = ctrl_reg[bcc_pkg::BCC_CTRL_SEL_LSB +: bcc_pkg::BCC_LABEL_W];

	// zero-wait slave: the access phase always completes in its first cycle
	assign pready = psel && penable;
	assign setup_phase = psel && !penable;
	assign access_wr = psel && penable && pwrite && is_mapped(paddr);
	assign wr_ctrl = access_wr && (paddr == bcc_pkg::BCC_OFS_CTRL);
	assign wr_seen = access_wr && (paddr == bcc_pkg::BCC_OFS_SEEN);
	assign wr_count = access_wr && (paddr == bcc_pkg::BCC_OFS_COUNT);

	// a sample counts only while capture runs, the trigger has not frozen it
	// and the observed processor is out of reset
	assign sample_active = capture_en && !frozen;
	assign match_hit = sample_active && class_q.valid
		&& (class_q.label == bcc_pkg::bcc_label_t'(match_sel));

	always_comb begin
		seen_set = 32'h0000_0000;
		if (sample_active && class_q.valid) begin
			seen_set[class_q.label] = 1'b1;
		end
	end

	// ---- capture path
	always_comb begin
		next_sample_q = sample_q;
		next_class_q = class_q;
		if (sample_active) begin
			next_sample_q = ctrl;
			next_class_q = live_class; // RQ13
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sample_q <= '0;
			class_q <= '{label: bcc_pkg::label_none, default: 1'b0};
		end else begin
			sample_q <= next_sample_q;
			class_q <= next_class_q;
		end
	end

	// ---- freeze on the selected label; writing control releases it
	always_comb begin
		next_frozen = frozen;
		if (wr_ctrl) begin
			next_frozen = 1'b0;
		end
		if (freeze_en && match_hit) begin
			next_frozen = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frozen <= 1'b0;
		end else begin
			frozen <= next_frozen;
		end
	end

	// ---- control register
	always_comb begin
		next_ctrl_reg = ctrl_reg;
		if (wr_ctrl) begin
			next_ctrl_reg = apply_strb(ctrl_reg, pwdata, pstrb) & bcc_pkg::BCC_CTRL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_reg <= bcc_pkg::BCC_CTRL_RESET;
		end else begin
			ctrl_reg <= next_ctrl_reg;
		end
	end

	// ---- sticky label history, write one to clear; a new hit beats the clear
	always_comb begin
		next_seen = seen;
		if (wr_seen) begin
			next_seen = seen & ~apply_strb(32'h0000_0000, pwdata, pstrb);
		end
		next_seen = next_seen | seen_set;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			seen <= 32'h0000_0000;
		end else begin
			seen <= next_seen;
		end
	end

	bcc_match_counter u_match_counter (
		.clk(clk),
		.reset_n(reset_n),
		.clear(wr_count),
		.hit(match_hit),
		.count(match_count)
	);

	// ---- read data, captured in the setup cycle so prdata is a flip-flop
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[bcc_pkg::BCC_STAT_LABEL_LSB +: bcc_pkg::BCC_LABEL_W] = class_q.label;
		status_word[bcc_pkg::BCC_STAT_UNCACHED_BIT] = class_q.uncached_fetch;
		status_word[bcc_pkg::BCC_STAT_MAINMEM_BIT] = class_q.main_mem_ifetch;
		status_word[bcc_pkg::BCC_STAT_VALID_BIT] = class_q.valid;
		status_word[bcc_pkg::BCC_STAT_FROZEN_BIT] = frozen;
	end

	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setup_phase) begin
			next_prdata = 32'h0000_0000;
			next_pslverr = !is_mapped(paddr);
			if (!pwrite) begin
				unique case (paddr)
					bcc_pkg::BCC_OFS_CTRL: next_prdata = ctrl_reg;
					bcc_pkg::BCC_OFS_STATUS: next_prdata = status_word;
					bcc_pkg::BCC_OFS_SAMPLE: next_prdata = {16'h0000, sample_q};
					bcc_pkg::BCC_OFS_SEEN: next_prdata = seen;
					bcc_pkg::BCC_OFS_COUNT: next_prdata = match_count;
					default: next_prdata = 32'h0000_0000;
				endcase
			end
		end else if (!psel) begin
			next_pslverr = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ---- label outputs straight from the capture flip-flops
	assign label = class_q.label;
	assign uncached_fetch = class_q.uncached_fetch;
	assign main_mem_ifetch = class_q.main_mem_ifetch;
	assign label_valid = class_q.valid;

endmodule // bcc_top

// ---- pkg/bcc_pkg.sv ----
package bcc_pkg;

	// one sample of the observed processor's control group, 16 bits
	typedef struct packed {
		logic run_stall;
		logic phase;
		logic exception_flag;
		logic memory_access_enable_n;
		logic icache_read_n;
		logic icache_write_n;
		logic dcache_read_n;
		logic dcache_write_n;
		logic main_mem_read_n;
		logic main_mem_write_n;
		logic read_busy;
		logic write_buffer_full_n;
		logic target_reset_n;
		logic [2:0] access_size;
	} bcc_ctrl_t;

	typedef enum logic [4:0] {
		label_none,
		label_held,
		label_stream_fetch,
		label_irun_swapped,
		label_irun_exception,
		label_irun,
		label_istall_retry,
		label_ifetch_fixup_read,
		label_ifetch_refill,
		label_ifetch_fixup,
		label_istall,
		label_drun_rd_byte,
		label_drun_rd_half,
		label_drun_rd_tri,
		label_drun_rd_word,
		label_drun_read,
		label_drun_swapped_read,
		label_drun_wr_byte,
		label_drun_wr_half,
		label_drun_wr_tri,
		label_drun_wr_word,
		label_drun_write,
		label_copro_move
	} bcc_label_t;

	typedef struct packed {
		bcc_label_t label;
		logic uncached_fetch;
		logic main_mem_ifetch;
		logic valid;
	} bcc_class_t;

	localparam int BCC_CTRL_W = 16;
	localparam int BCC_LABEL_W = 5;

	localparam logic [1:0] BCC_SIZE_BYTE = 2'h0;
	localparam logic [1:0] BCC_SIZE_HALF = 2'h1;
	localparam logic [1:0] BCC_SIZE_TRI = 2'h2;
	localparam logic [1:0] BCC_SIZE_WORD = 2'h3;

	localparam logic [7:0] BCC_OFS_CTRL = 8'h00;
	localparam logic [7:0] BCC_OFS_STATUS = 8'h04;
	localparam logic [7:0] BCC_OFS_SAMPLE = 8'h08;
	localparam logic [7:0] BCC_OFS_SEEN = 8'h0C;
	localparam logic [7:0] BCC_OFS_COUNT = 8'h10;

	localparam int BCC_CTRL_ENABLE_BIT = 0;
	localparam int BCC_CTRL_FREEZE_BIT = 1;
	localparam int BCC_CTRL_SEL_LSB = 8;
	localparam logic [31:0] BCC_CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] BCC_CTRL_MASK = 32'h0000_1F03;

	localparam int BCC_STAT_LABEL_LSB = 0;
	localparam int BCC_STAT_UNCACHED_BIT = 8;
	localparam int BCC_STAT_MAINMEM_BIT = 9;
	localparam int BCC_STAT_VALID_BIT = 10;
	localparam int BCC_STAT_FROZEN_BIT = 11;

	localparam logic [31:0] BCC_COUNT_MAX = 32'hFFFF_FFFF;

endpackage

// ---- rtl/bcc_classify.sv ----
`timescale 1ns/1ps
module bcc_classify (
	input wire bcc_pkg::bcc_ctrl_t ctrl,
	output bcc_pkg::bcc_class_t result
);

	function automatic bcc_pkg::bcc_label_t size_label(input logic is_write,
			input logic [1:0] size);
		bcc_pkg::bcc_label_t lbl;
		lbl = bcc_pkg::label_none;
		unique case (size)
			bcc_pkg::BCC_SIZE_BYTE: lbl = is_write ? bcc_pkg::label_drun_wr_byte
				: bcc_pkg::label_drun_rd_byte;
			bcc_pkg::BCC_SIZE_HALF: lbl = is_write ? bcc_pkg::label_drun_wr_half
				: bcc_pkg::label_drun_rd_half;
			bcc_pkg::BCC_SIZE_TRI: lbl = is_write ? bcc_pkg::label_drun_wr_tri
				: bcc_pkg::label_drun_rd_tri;
			bcc_pkg::BCC_SIZE_WORD: lbl = is_write ? bcc_pkg::label_drun_wr_word
				: bcc_pkg::label_drun_rd_word;
		endcase
		return lbl;
	endfunction

	always_comb begin
		result = '0;
		result.label = bcc_pkg::label_none;
		result.valid = ctrl.target_reset_n;
		// first matching row wins, held target classifies nothing
		if (!ctrl.target_reset_n) begin // RQ13
			result.label = bcc_pkg::label_held;
		end else if (!ctrl.run_stall && ctrl.phase) begin
			if (!ctrl.memory_access_enable_n) begin
				result.label = bcc_pkg::label_stream_fetch; // RQ1
			end else if (!ctrl.dcache_read_n) begin
				result.label = bcc_pkg::label_irun_swapped; // RQ2
			end else if (!ctrl.exception_flag) begin
				result.label = bcc_pkg::label_irun_exception; // RQ2
			end else begin
				result.label = bcc_pkg::label_irun; // RQ2
			end
		end else if (ctrl.run_stall && ctrl.phase) begin
			if (!ctrl.memory_access_enable_n && ctrl.read_busy) begin
				result.label = bcc_pkg::label_istall_retry; // RQ3
			end else if (!ctrl.memory_access_enable_n) begin
				result.label = ctrl.exception_flag ? bcc_pkg::label_ifetch_refill
					: bcc_pkg::label_ifetch_fixup_read; // RQ4
			end else begin
				result.label = ctrl.exception_flag ? bcc_pkg::label_istall
					: bcc_pkg::label_ifetch_fixup; // RQ5
			end
		end else if (!ctrl.run_stall && !ctrl.phase) begin
			if (!ctrl.dcache_read_n) begin
				result.label = ctrl.access_size[2] ? bcc_pkg::label_drun_read // RQ9
					: size_label(1'b0, ctrl.access_size[1:0]); // RQ8
			end else if (!ctrl.icache_read_n) begin
				result.label = bcc_pkg::label_drun_swapped_read; // RQ10
			end else if (!ctrl.main_mem_write_n) begin
				result.label = ctrl.access_size[2] ? bcc_pkg::label_drun_write // RQ12
					: size_label(1'b1, ctrl.access_size[1:0]); // RQ11
			end else if (ctrl.memory_access_enable_n && ctrl.icache_write_n
					&& ctrl.dcache_write_n && !ctrl.access_size[2]) begin
				result.label = bcc_pkg::label_copro_move; // RQ14
			end
		end
		// these two ignore run_stall and sit beside the exclusive label
		result.uncached_fetch = ctrl.target_reset_n && ctrl.phase
			&& !ctrl.memory_access_enable_n && ctrl.icache_write_n
			&& ctrl.dcache_write_n; // RQ6
		result.main_mem_ifetch = ctrl.target_reset_n && ctrl.phase
			&& !ctrl.memory_access_enable_n; // RQ7
	end

endmodule // bcc_classify

// ---- rtl/bcc_match_counter.sv ----
`timescale 1ns/1ps
module bcc_match_counter (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic hit,
	output logic [31:0] count
);

	logic [31:0] next_count;

	// saturates rather than wraps so a long run never reads as a short one
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = 32'h0000_0000;
		end
		if (hit && (next_count != bcc_pkg::BCC_COUNT_MAX)) begin
			next_count = next_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= 32'h0000_0000;
		end else begin
			count <= next_count;
		end
	end

endmodule // bcc_match_counter

// ---- verification/bcc_top_sva.sv ----
`timescale 1ns/1ps
module bcc_top_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire bcc_pkg::bcc_ctrl_t ctrl,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire bcc_pkg::bcc_label_t label,
	input wire logic uncached_fetch,
	input wire logic main_mem_ifetch,
	input wire logic label_valid
);
	bcc_pkg::bcc_ctrl_t p;
	logic cap, next_cap, pv, g, r, s, d;
	// freeze is treated as capture off: matches are not visible from here
	always_comb begin
		next_cap = cap;
		if (psel && penable && pwrite && paddr == 8'h00 && pstrb[0])
			next_cap = pwdata[0] && !pwdata[1];
	end
	always_ff @(posedge clk) begin
		cap <= reset_n ? next_cap : 1'h1;
		pv <= reset_n && cap;
		p <= ctrl;
	end
	assign g = pv && p.target_reset_n;
	assign r = !p.run_stall && p.phase;
	assign s = p.run_stall && p.phase;
	assign d = !p.run_stall && !p.phase;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_stream_fetch: assert property (g && r && !p.memory_access_enable_n
		|-> label == bcc_pkg::label_stream_fetch) else $error("stream fetch label wrong");
	a_irun_swapped: assert property (g && r && p.memory_access_enable_n && !p.dcache_read_n
		|-> label == bcc_pkg::label_irun_swapped) else $error("swapped run label wrong");
	a_retry_read: assert property (g && s && !p.memory_access_enable_n && p.read_busy
		|-> label == bcc_pkg::label_istall_retry) else $error("retry label wrong");
	a_fixup_refill: assert property (g && s && !p.memory_access_enable_n && !p.read_busy
		|-> label == (p.exception_flag ? bcc_pkg::label_ifetch_refill :
		bcc_pkg::label_ifetch_fixup_read)) else $error("fixup or refill label wrong");
	a_stall_fixup: assert property (g && s && p.memory_access_enable_n
		|-> label == (p.exception_flag ? bcc_pkg::label_istall : bcc_pkg::label_ifetch_fixup))
		else $error("stall or fixup label wrong");
	a_uncached_flag: assert property (g |-> uncached_fetch == (p.phase &&
		!p.memory_access_enable_n && p.icache_write_n && p.dcache_write_n))
		else $error("uncached flag wrong");
	a_mainmem_flag: assert property (g
		|-> main_mem_ifetch == (p.phase && !p.memory_access_enable_n))
		else $error("main memory flag wrong");
	a_sized_read: assert property (g && d && !p.dcache_read_n && !p.access_size[2]
		|-> label == bcc_pkg::label_drun_rd_byte + p.access_size[1:0])
		else $error("sized read label wrong");
	a_sized_write: assert property (g && d && p.dcache_read_n && p.icache_read_n &&
		!p.main_mem_write_n && !p.access_size[2]
		|-> label == bcc_pkg::label_drun_wr_byte + p.access_size[1:0])
		else $error("sized write label wrong");
	a_swapped_read: assert property (g && d && p.dcache_read_n && !p.icache_read_n
		|-> label == bcc_pkg::label_drun_swapped_read) else $error("swapped read label wrong");
	a_copro_move: assert property (g && d && p.memory_access_enable_n && p.icache_read_n
		&& p.icache_write_n && p.dcache_read_n && p.dcache_write_n && p.main_mem_write_n
		&& !p.access_size[2] |-> label == bcc_pkg::label_copro_move)
		else $error("coprocessor label wrong");
	a_held_label: assert property (reset_n && cap && !ctrl.target_reset_n
		|=> label == bcc_pkg::label_held && !label_valid) else $error("held label wrong");
endmodule // bcc_top_sva

bind bcc_top bcc_top_sva bcc_top_sva_i (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.label(label), .uncached_fetch(uncached_fetch), .main_mem_ifetch(main_mem_ifetch),
	.label_valid(label_valid));

// ---- verification/bcc_cpu_model.sv ----
`timescale 1ns/1ps
module bcc_cpu_model (
	input wire logic clk,
	input wire bcc_pkg::bcc_ctrl_t want,
	output bcc_pkg::bcc_ctrl_t ctrl
);
	// idle core: strobes inactive, out of reset
	initial ctrl = 16'hFFFF;
	// the core launches its control group just after its clock edge
	always @(posedge clk) begin
		ctrl <= want;
	end
endmodule // bcc_cpu_model

// ---- verification/bcc_top_test.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module bcc_top_test;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, uncached_fetch, main_mem_ifetch, label_valid, er;
	bcc_pkg::bcc_ctrl_t want = 16'hFFFF;
	bcc_pkg::bcc_ctrl_t ctrl, c;
	bcc_pkg::bcc_label_t label, lb;
	int error_cnt = 0;
	int n_checks = 0;
	always #20 clk = ~clk;
	bcc_cpu_model bcc_cpu_model_i (.clk(clk), .want(want), .ctrl(ctrl));
	bcc_top bcc_top_i (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .label(label),
		.uncached_fetch(uncached_fetch), .main_mem_ifetch(main_mem_ifetch),
		.label_valid(label_valid));
	task final_report;
		$display("errors %0d checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// rpe = run_stall, phase, exception_flag, memory_access_enable_n
	function automatic bcc_pkg::bcc_ctrl_t mk(input logic [3:0] rpe, input logic [5:0] st,
		input logic busy, input logic [2:0] sz);
		return {rpe, st, busy, 1'h1, 1'h1, sz};
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'h1;
		// no cycle limit here: only the watchdog ends a hung access
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	// ctrl lands one edge later, the label one edge after that
	task cls(input bcc_pkg::bcc_ctrl_t x, input bcc_pkg::bcc_label_t e, input logic [1:0] f);
		want <= x;
		repeat (3) @(posedge clk);
		`CHK(label, e)
		`CHK({uncached_fetch, main_mem_ifetch}, f)
		`CHK(label_valid, x.target_reset_n)
	endtask
	initial begin
		#100000;
		error_cnt++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		apb(1'h0, 8'h00, 32'h0);
		`CHK(rd, 32'h0000_0001)
		cls(mk(4'h6, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_stream_fetch, 2'h3);
		cls(mk(4'h6, 6'h2F, 1'h0, 3'h0), bcc_pkg::label_stream_fetch, 2'h1);
		cls(mk(4'h5, 6'h37, 1'h0, 3'h0), bcc_pkg::label_irun_swapped, 2'h0);
		cls(mk(4'h5, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_irun_exception, 2'h0);
		cls(mk(4'h7, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_irun, 2'h0);
		cls(mk(4'hC, 6'h3F, 1'h1, 3'h0), bcc_pkg::label_istall_retry, 2'h3);
		cls(mk(4'hC, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_ifetch_fixup_read, 2'h3);
		cls(mk(4'hE, 6'h3B, 1'h0, 3'h0), bcc_pkg::label_ifetch_refill, 2'h1);
		cls(mk(4'hD, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_ifetch_fixup, 2'h0);
		cls(mk(4'hF, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_istall, 2'h0);
		for (int i = 0; i < 4; i++) begin
			lb = bcc_pkg::bcc_label_t'(bcc_pkg::label_drun_rd_byte + i);
			cls(mk(4'h3, 6'h37, 1'h0, 3'(i)), lb, 2'h0);
			lb = bcc_pkg::bcc_label_t'(bcc_pkg::label_drun_wr_byte + i);
			cls(mk(4'h3, 6'h3E, 1'h0, 3'(i)), lb, 2'h0);
		end
		cls(mk(4'h3, 6'h37, 1'h0, 3'h4), bcc_pkg::label_drun_read, 2'h0);
		cls(mk(4'h3, 6'h17, 1'h0, 3'h5), bcc_pkg::label_drun_read, 2'h0);
		cls(mk(4'h3, 6'h1F, 1'h0, 3'h0), bcc_pkg::label_drun_swapped_read, 2'h0);
		cls(mk(4'h3, 6'h3E, 1'h0, 3'h6), bcc_pkg::label_drun_write, 2'h0);
		cls(mk(4'h2, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_none, 2'h0);
		cls(mk(4'h3, 6'h3F, 1'h0, 3'h4), bcc_pkg::label_none, 2'h0);
		c = mk(4'h3, 6'h3F, 1'h0, 3'h3);
		cls(c, bcc_pkg::label_copro_move, 2'h0);
		apb(1'h0, 8'h04, 32'h0);
		`CHK(rd, 32'h0000_0416)
		apb(1'h0, 8'h08, 32'h0);
		`CHK(rd, {16'h0, c})
		apb(1'h0, 8'h40, 32'h0);
		`CHK({er, rd}, 33'h1_0000_0000)
		// freeze on the coprocessor label: one counted hit, then capture stops
		apb(1'h1, 8'h10, 32'h0);
		apb(1'h1, 8'h00, 32'h0000_1603);
		apb(1'h0, 8'h10, 32'h0);
		`CHK(rd, 32'h0000_0001)
		apb(1'h0, 8'h04, 32'h0);
		`CHK(rd, 32'h0000_0C16)
		apb(1'h1, 8'h0C, 32'hFFFF_FFFF);
		apb(1'h0, 8'h0C, 32'h0);
		`CHK(rd, 32'h0000_0000)
		apb(1'h1, 8'h00, 32'h0000_0001);
		apb(1'h0, 8'h0C, 32'h0);
		`CHK(rd, 32'h0040_0000)
		// capture off: the last label must stay put
		apb(1'h1, 8'h00, 32'h0);
		cls(mk(4'h6, 6'h3F, 1'h0, 3'h0), bcc_pkg::label_copro_move, 2'h0);
		apb(1'h1, 8'h00, 32'h0000_0001);
		c = mk(4'h6, 6'h3F, 1'h0, 3'h0);
		c.target_reset_n = 1'h0;
		cls(c, bcc_pkg::label_held, 2'h0);
		final_report;
	end
endmodule // bcc_top_test
